// file: hdl/kbli_top.sv
// keypad level interrupt port: four level-sensitive inputs, two registers
// assumes the core gives one-cycle read and write strobes on CLK_I
`timescale 1ns/1ps
`include "kbli_map.svh"

module kbli_top
  import kbli_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // special function register access
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  output logic      [7:0] SFR_RDATA_O,
  // global enable from the core interrupt enable register
  input  wire logic       KB_IRQ_GLOBAL_EN_I,
  // keypad pins
  input  wire logic [3:0] KEYPAD_INPUTS_I,
  // interrupt and wake
  output logic            KB_IRQ_O,
  output logic            WAKE_IDLE_O,
  output logic            WAKE_PD_O
);

  // ==========================================================
  // pin synchronisers
  kbli_nib_t pin_s1_reg;
  kbli_nib_t pin_s2_reg;
  kbli_nib_t pin_s1_next;
  kbli_nib_t pin_s2_next;

  always_comb begin
    pin_s1_next = KEYPAD_INPUTS_I;
    pin_s2_next = pin_s1_reg;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      // idle rows sit high on their pull-ups; a low reset value would fake a
      // low-level match on every input just after reset
      pin_s1_reg <= 4'hF;
      pin_s2_reg <= 4'hF;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
    end
  end

  // ==========================================================
  // registers and flags
  kbli_sfr_s  sfr;
  kbli_ctrl_s ctrl_reg;
  kbli_ctrl_s ctrl_next;
  logic       pde_reg;
  logic       pde_next;
  kbli_nib_t  flag_reg;
  kbli_nib_t  flag_next;
  kbli_nib_t  match;
  kbli_stat_s stat_view;
  kbli_byte_t rdata_reg;
  kbli_byte_t rdata_next;
  logic       stat_rd;

  assign sfr = '{addr: SFR_ADDR_I, wdata: SFR_WDATA_I, wr: SFR_WR_I, rd: SFR_RD_I};

  // per-input level compare
  // xnor gives one where the pin equals its selected level
  assign match = ~(pin_s2_reg ^ ctrl_reg.level);

  assign stat_rd = sfr.rd && (sfr.addr == `KBLI_STAT_ADDR);

  always_comb begin
    stat_view      = '0;
    stat_view.pde  = pde_reg;
    stat_view.rsvd = 3'h0;
    stat_view.flag = flag_reg;
  end

  always_comb begin
    ctrl_next  = ctrl_reg;
    pde_next   = pde_reg;
    flag_next  = flag_reg;
    rdata_next = rdata_reg;
    if (sfr.wr && (sfr.addr == `KBLI_CTRL_ADDR)) begin
      ctrl_next = kbli_ctrl_s'(sfr.wdata);
    end
    // flags are not writable; only the wake enable takes a write
    if (sfr.wr && (sfr.addr == `KBLI_STAT_ADDR)) begin
      pde_next = sfr.wdata[`KBLI_PDE_BIT];
    end
    if (sfr.rd) begin
      unique case (sfr.addr)
        `KBLI_CTRL_ADDR: rdata_next = kbli_byte_t'(ctrl_reg);
        `KBLI_STAT_ADDR: rdata_next = kbli_byte_t'(stat_view);
        default:         rdata_next = 8'h00;
      endcase
    end
    if (stat_rd) begin
      flag_next = 4'h0;
    end
    // set after clear, so a held key re-flags at once
    flag_next = flag_next | match;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg  <= kbli_ctrl_s'(`KBLI_CTRL_RESET);
      pde_reg   <= 1'b0;
      flag_reg  <= 4'h0;
      rdata_reg <= `KBLI_STAT_RESET;
    end else begin
      ctrl_reg  <= ctrl_next;
      pde_reg   <= pde_next;
      flag_reg  <= flag_next;
      rdata_reg <= rdata_next;
    end
  end

  assign SFR_RDATA_O = rdata_reg;

  // ==========================================================
  // interrupt and wake outputs
  // the clock-free wake path of power-down sits in the power controller;
  // this port only offers the clocked request it should gate with
  logic irq_raw;
  logic irq_reg;
  logic irq_next;
  logic widle_reg;
  logic widle_next;
  logic wpd_reg;
  logic wpd_next;

  // any unmasked flag raises one request
  assign irq_raw = |(flag_reg & ~ctrl_reg.mask);

  always_comb begin
    irq_next   = irq_raw && KB_IRQ_GLOBAL_EN_I;
    widle_next = irq_raw && KB_IRQ_GLOBAL_EN_I;
    // spurious wakes are left for software to resolve
    wpd_next   = irq_raw && KB_IRQ_GLOBAL_EN_I && pde_reg;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_reg   <= 1'b0;
      widle_reg <= 1'b0;
      wpd_reg   <= 1'b0;
    end else begin
      irq_reg   <= irq_next;
      widle_reg <= widle_next;
      wpd_reg   <= wpd_next;
    end
  end

  assign KB_IRQ_O    = irq_reg;
  assign WAKE_IDLE_O = widle_reg;
  assign WAKE_PD_O   = wpd_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_status_read;
    SFR_RD_I && (SFR_ADDR_I == `KBLI_STAT_ADDR);
  endsequence

  sequence s_quiet_inputs;
    match == 4'h0;
  endsequence

  sequence s_unmasked_pending;
    (|(flag_reg & ~ctrl_reg.mask)) && KB_IRQ_GLOBAL_EN_I;
  endsequence

  property p_flag_follows_level;
    (flag_reg & $past(match)) == $past(match);
  endproperty
  a_flag_follows_level: assert property (p_flag_follows_level)
    else $error("flag missing after input matched its level");

  property p_level_select;
    (pin_s2_reg == 4'hF && ctrl_reg.level == 4'h0) |-> match == 4'h0;
  endproperty
  a_level_select: assert property (p_level_select)
    else $error("high pins matched while low level selected");

  property p_read_clears;
    (s_status_read ##0 s_quiet_inputs) |=> flag_reg == 4'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  property p_held_reflags;
    (s_status_read ##0 (match != 4'h0)) |=> (flag_reg & $past(match)) != 4'h0;
  endproperty
  a_held_reflags: assert property (p_held_reflags)
    else $error("held key lost its flag over a status read");

  property p_irq_cause;
    KB_IRQ_O == $past((|(flag_reg & ~ctrl_reg.mask)) && KB_IRQ_GLOBAL_EN_I);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt does not follow unmasked flags");

  property p_mask_blocks;
    (ctrl_reg.mask == 4'hF) [*2] |-> !KB_IRQ_O;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("interrupt raised with all flags masked");

  property p_global_gate;
    !KB_IRQ_GLOBAL_EN_I |=> !KB_IRQ_O && !WAKE_IDLE_O && !WAKE_PD_O;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("keypad request passed with global enable off");

  property p_pd_wake;
    (s_unmasked_pending ##0 pde_reg) |=> WAKE_PD_O;
  endproperty
  a_pd_wake: assert property (p_pd_wake)
    else $error("power-down wake missing while enabled");

  property p_pd_blocked;
    !pde_reg |=> !WAKE_PD_O;
  endproperty
  a_pd_blocked: assert property (p_pd_blocked)
    else $error("power-down wake with wake enable clear");

  property p_idle_wake;
    s_unmasked_pending |=> WAKE_IDLE_O && KB_IRQ_O;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle wake missing on keypad interrupt");

  property p_reserved_zero;
    s_status_read |=> SFR_RDATA_O[6:4] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

  property p_reset_ctrl;
    $fell(RST_I) |-> kbli_byte_t'(ctrl_reg) == `KBLI_CTRL_RESET;
  endproperty
  a_reset_ctrl: assert property (@(posedge CLK_I) p_reset_ctrl)
    else $error("control register reset value wrong");

endmodule

// file: hdl/kbli_map.svh
// constants for the four-input keypad level interrupt port
// assumes an 8-bit special function register space on the core side
// Summary of operation
// - level bit one high, zero low detect
// - matching input level sets its flag
// - status read clears all four flags (here a still-matching input re-sets its flag at once)
// - mask one blocks flag, zero passes it (here a masked flag still sets; the mask gates only the request)
// - four sources share one interrupt request
// - global enable gates combined keypad request
// - wake enable lets interrupt end power-down
// - keypad inputs also end idle mode
// - clockless detection (here clocked; this port only gives the power controller a request); software re-enters power-down
// - status bits six to four read zero
// - control resets to all-low, all-masked
`ifndef KBLI_MAP_SVH
`define KBLI_MAP_SVH

// ==========================================================
// register addresses in special function space
`define KBLI_CTRL_ADDR  8'hA3
`define KBLI_STAT_ADDR  8'hA4

// ==========================================================
// reset values
`define KBLI_CTRL_RESET 8'h0F
`define KBLI_STAT_RESET 8'h00

// ==========================================================
// field positions
`define KBLI_LVL_MSB    7
`define KBLI_LVL_LSB    4
`define KBLI_MSK_MSB    3
`define KBLI_MSK_LSB    0
`define KBLI_PDE_BIT    7
`define KBLI_FLG_MSB    3
`define KBLI_FLG_LSB    0

`endif

// file: hdl/kbli_pkg.sv
// types shared by the keypad level interrupt port
// assumes kbli_map.svh is on the include path
package kbli_pkg;

  typedef logic [3:0] kbli_nib_t;
  typedef logic [7:0] kbli_byte_t;

  // control register layout, level bits high, mask bits low
  typedef struct packed {
    kbli_nib_t level;
    kbli_nib_t mask;
  } kbli_ctrl_s;

  // status register layout; reserved bits kept as a field
  typedef struct packed {
    logic      pde;
    logic [2:0] rsvd;
    kbli_nib_t flag;
  } kbli_stat_s;

  // one register access from the core
  typedef struct packed {
    kbli_byte_t addr;
    kbli_byte_t wdata;
    logic       wr;
    logic       rd;
  } kbli_sfr_s;

endpackage

// file: verif/kbli_keys.sv
// key matrix model: four rows, each with a pull-up
// assumes the bench says which rows have a key held down
`timescale 1ns/1ps

module kbli_keys (
  // key state from the bench
  input  wire logic [3:0] press_i,
  // rows to the keypad pins
  output logic      [3:0] rows_o
);
  // ==========================================================
  // rows
  // a released row is pulled up, never left floating
  assign rows_o = ~press_i;
endmodule

// file: verif/keypad_level_interrupt_tb_top.sv
// self-checking bench for the keypad level interrupt port
// assumes kbli_pkg is compiled first and kbli_map.svh is on the include path
`timescale 1ns/1ps
`include "kbli_map.svh"

module keypad_level_interrupt_tb_top;
  import kbli_pkg::*;
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  kbli_sfr_s  sfr       = '0;
  logic       gen       = 1'b0;
  kbli_nib_t  press     = 4'h0;
  kbli_nib_t  rows;
  kbli_byte_t rdata;
  logic       irq;
  logic       wk_idle;
  logic       wk_pd;
  int         err_total = 0;
  int         n_tests   = 0;
  int         seed      = 78;
  kbli_nib_t  lvl;
  logic       pde;

  always #10 clk = ~clk;

  kbli_keys keys (.press_i(press), .rows_o(rows));

  kbli_top DUT (
    .CLK_I              (clk),
    .RST_I              (rst),
    .SFR_ADDR_I         (sfr.addr),
    .SFR_WDATA_I        (sfr.wdata),
    .SFR_WR_I           (sfr.wr),
    .SFR_RD_I           (sfr.rd),
    .SFR_RDATA_O        (rdata),
    .KB_IRQ_GLOBAL_EN_I (gen),
    .KEYPAD_INPUTS_I    (rows),
    .KB_IRQ_O           (irq),
    .WAKE_IDLE_O        (wk_idle),
    .WAKE_PD_O          (wk_pd)
  );

  // ==========================================================
  // helpers
  function automatic kbli_byte_t exp_stat(input logic p, input int i);
    return {p, 3'h0, 4'h1 << i};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one strobe cycle; read data is settled on return
  task automatic acc(input kbli_byte_t a, input kbli_byte_t d, input logic w);
    @(posedge clk);
    sfr <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk);
    sfr <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask

  task automatic end_sim();
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    acc(`KBLI_CTRL_ADDR, 8'h00, 1'b0);
    chk(rdata, `KBLI_CTRL_RESET); // reset value
    acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
    chk(rdata, 8'h00); // reserved zero
    acc(8'h55, 8'h00, 1'b0);
    chk(rdata, 8'h00);
    @(posedge clk);
    gen   <= 1'b1;
    press <= 4'h4;
    cyc(6);
    chk({7'h0, irq}, 8'h00); // masked flag
    acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
    chk(rdata, 8'h04); // low level flag
    acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
    chk(rdata, 8'h04); // held key
    @(posedge clk);
    press <= 4'h0;
    cyc(4);
    acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
    chk(rdata, 8'h04); // set at last read
    acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
    chk(rdata, 8'h00); // read clears
    for (int i = 0; i < 4; i++) begin
      lvl = 4'($random(seed));
      pde = 1'($random(seed));
      acc(`KBLI_CTRL_ADDR, {lvl, 4'h0}, 1'b1);
      acc(`KBLI_STAT_ADDR, {pde, 7'h0}, 1'b1);
      @(posedge clk);
      press <= lvl ^ (4'h1 << i);
      cyc(6);
      // stale flags from the level change go here
      acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
      cyc(4);
      chk({5'h0, irq, wk_idle, wk_pd}, {5'h0, 2'b11, pde}); // wake
      acc(`KBLI_STAT_ADDR, 8'h00, 1'b0);
      chk(rdata, exp_stat(pde, i)); // single flag
      acc(`KBLI_CTRL_ADDR, {lvl, 4'h1 << i}, 1'b1);
      cyc(3);
      chk({7'h0, irq}, 8'h00); // mask one
      acc(`KBLI_CTRL_ADDR, {lvl, 4'h0}, 1'b1);
      @(posedge clk);
      gen <= 1'b0;
      cyc(3);
      chk({7'h0, irq}, 8'h00); // global off
      @(posedge clk);
      gen <= 1'b1;
      cyc(3);
      chk({7'h0, irq}, 8'h01); // global on
      acc(`KBLI_CTRL_ADDR, 8'h00, 1'b0);
      chk(rdata, {lvl, 4'h0}); // level readback
    end
    end_sim();
  end

  // ==========================================================
  // hang guard
  initial begin
    #500000;
    err_total++;
    end_sim();
  end
endmodule
